// >>> hw/plt_pkg.sv
// shared types and constants for the passive panel timing generator
package plt_pkg;

   // panel data formats handled by the generator
   typedef enum logic [1:0] {
      FMT_MONO4,
      FMT_MONO8,
      FMT_COLOR4
   } plt_format_t;

   // panel output sequencing states
   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_RUN,
      PWR_DRAIN
   } plt_power_t;

   // static configuration, held steady while the panel runs
   typedef struct packed {
      logic [6:0] h_active;   // active width in units of 8 pixels, minus 1
      logic [7:0] h_blank;    // blanking in units of 8 pixels, minus 4
      logic [9:0] v_active;   // active lines minus 1
      logic [5:0] v_blank;    // blanking lines
      plt_format_t format;    // panel data format
      logic clk_div;          // halve the input clock
      logic shift_gate;       // shift clock only inside the data window
   } plt_cfg_t;

   // counter widths
   localparam int H2_W = 12;
   localparam int V_W = 11;
   localparam int SPH_W = 5;
   localparam int MON_W = 16;

   // core clock rate and the input clock limit for running undivided
   localparam int CORE_CLK_MHZ = 200;
   localparam int UNDIVIDED_MAX_MHZ = 25;

   // horizontal timing, in pixel periods
   localparam int HALVES_PER_TS = 2;
   localparam int H_UNIT_TS = 8;
   localparam int H_BLANK_BASE = 4;
   localparam int H_BLANK_USED_BITS = 5;
   localparam int LINE_PULSE_TS = 9;
   localparam int FRAME_HOLD_TS = 9;
   localparam int SHIFT_LEAD_TS = 23;
   localparam int AC_DELAY_TS = 1;

   // shift clock half cycle per format, in half pixel periods
   localparam logic [3:0] SHIFT_HALF_MONO4 = 4'h4;
   localparam logic [3:0] SHIFT_HALF_MONO8 = 4'h8;
   localparam logic [3:0] SHIFT_HALF_COLOR4 = 4'h1;

   // power sequencing, in frames
   localparam int DRAIN_FRAMES_TYP = 127;
   localparam int DRAIN_W = 7;

   // reset values
   localparam plt_power_t POWER_RESET = PWR_OFF;
   localparam logic [7:0] BUS_RESET = 8'h00;

endpackage : plt_pkg

// >>> hw/plt_panel_timing.sv
// passive panel timing generator with power sequencing
`timescale 1ns/1ps

// Behaviour
// RULE1: divide bit halves input clock internally
// RULE2: outputs go active within one frame
// RULE3: panel power only with outputs active
// RULE4: forced off: power save stops outputs
// RULE5: forced off: save release restarts outputs
// RULE6: save starts shutdown within one frame
// RULE7: outputs run 127 frames after power drops
// RULE8: save release restores outputs and power
// RULE9: force-off drops power, release restores it
// RULE10: active lines equal field plus one
// RULE11: blank lines equal blanking field
// RULE12: active width is eight times field+1
// RULE13: blank width is eight times field+4
// RULE14: frame pulse held nine periods past line
// RULE15: line pulse nine wide, full line period
// RULE16: modulation flips one period after line
// RULE17: first shift rise 23 periods after line
// RULE18: mono4 nibble, four-period shift cycle
// RULE19: mono4 last shift fall lead times
// RULE20: mono8 byte, eight-period shift cycle
// RULE21: mono8 last shift fall lead times
// RULE22: shift clock gate control input
// RULE23: color4 nibble, one-period shift cycle
// RULE24: pixel period from divided clock, 5 bits
module plt_panel_timing #(
   parameter int DRAIN_FRAMES = plt_pkg::DRAIN_FRAMES_TYP
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // configuration and power controls
   input wire plt_pkg::plt_cfg_t CFG,
   input wire logic DISPLAY_ON,
   input wire logic HW_POWER_SAVE,
   input wire logic POWER_FORCE_OFF,
   // pixel source
   input wire logic [7:0] PIXEL_DATA,
   output logic PIXEL_REQ,
   // panel pins
   output logic PANEL_LINE_PULSE,
   output logic PANEL_FRAME_PULSE,
   output logic PANEL_SHIFT_CLOCK,
   output logic [7:0] PANEL_PIXEL_BUS,
   output logic PANEL_DATA_ENABLE,
   output logic PANEL_AC_MODULATION,
   output logic PANEL_POWER_ENABLE
);

   // counters and derived timing
   logic div_phase;                    // divider toggle
   logic half_tick;                    // one half pixel period elapsed
   logic step_first;                   // first cycle of a half step
   logic [plt_pkg::H2_W-1:0] h2;       // line position, half periods
   logic [plt_pkg::V_W-1:0] v;         // line number in frame
   logic [plt_pkg::SPH_W-1:0] sph;     // shift phase, half periods
   logic [plt_pkg::H2_W-1:0] act_halves;
   logic [plt_pkg::H2_W-1:0] blank_halves;
   logic [plt_pkg::H2_W-1:0] line_halves;
   logic [plt_pkg::V_W-1:0] frame_lines;
   logic [plt_pkg::H2_W-1:0] win_start;
   logic [plt_pkg::H2_W-1:0] win_end;
   logic [3:0] shift_half;
   logic last_h;
   logic last_v;
   logic line_end_tick;
   logic frame_start_tick;
   logic display_line;
   logic in_window;
   logic in_data;
   logic load;
   // pixel staging
   logic [7:0] stage;
   logic stage_valid;
   logic req;
   // sequencing
   plt_pkg::plt_power_t pstate;
   logic [plt_pkg::DRAIN_W-1:0] drain_left;
   logic power_on;
   logic run;
   logic out_on;                       // outputs are live this cycle
   logic ac_phase;
   logic ac_flip;
   // next panel values before gating
   logic next_line;
   logic next_frame;
   logic next_shift;
   logic [7:0] next_bus;
   logic next_de;

   // divided step rate; the shift clock of colour panels needs half
   // pixel resolution, so the counters run at twice the pixel rate
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         div_phase <= 1'b0;
      else if (CFG.clk_div)
         div_phase <= ~div_phase;      // [RULE1]
      else
         div_phase <= 1'b0;
   end

   assign half_tick = ~CFG.clk_div | div_phase; // [RULE1] [RULE24]

   // marks the first cycle after a step so single events fire once
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         step_first <= 1'b1;
      else
         step_first <= half_tick;
   end

   // line and frame lengths from the configuration
   always_comb
   begin
      act_halves = ({5'h00, CFG.h_active} + 12'h001)
         * 12'(plt_pkg::HALVES_PER_TS * plt_pkg::H_UNIT_TS); // [RULE12]
      // only the low blanking bits count
      blank_halves = ({7'h00, CFG.h_blank[plt_pkg::H_BLANK_USED_BITS-1:0]}
         + 12'(plt_pkg::H_BLANK_BASE)) // [RULE13] [RULE24]
         * 12'(plt_pkg::HALVES_PER_TS * plt_pkg::H_UNIT_TS);
      line_halves = act_halves + blank_halves; // [RULE15]
      frame_lines = {1'b0, CFG.v_active} + 11'h001
         + {5'h00, CFG.v_blank};        // [RULE10] [RULE11]
      // shift cycle per format
      case (CFG.format)
         plt_pkg::FMT_MONO8:
            shift_half = plt_pkg::SHIFT_HALF_MONO8; // [RULE20]
         plt_pkg::FMT_COLOR4:
            shift_half = plt_pkg::SHIFT_HALF_COLOR4; // [RULE23]
         default: shift_half = plt_pkg::SHIFT_HALF_MONO4; // [RULE18]
      endcase
      // window starts half a shift cycle before the first rise, so the
      // last fall leads the next line by eight times the blanking field plus that half
      win_start = 12'(plt_pkg::HALVES_PER_TS
         * (plt_pkg::LINE_PULSE_TS + plt_pkg::SHIFT_LEAD_TS))
         - {8'h00, shift_half};         // [RULE17] [RULE19] [RULE21]
      win_end = win_start + act_halves;
   end

   assign last_h = (h2 == line_halves - 12'h001);
   assign last_v = (v == frame_lines - 11'h001);
   assign line_end_tick = half_tick & last_h;
   assign frame_start_tick = line_end_tick & last_v;
   assign display_line = (v <= {1'b0, CFG.v_active}); // [RULE10]
   assign in_window = display_line & (h2 >= win_start) & (h2 < win_end);
   assign in_data = display_line & (h2 >= win_start + {8'h00, shift_half})
      & (h2 < win_end + {8'h00, shift_half});
   // data changes on each shift rise, held half a cycle either side
   assign load = step_first & in_window
      & (sph == {1'b0, shift_half}); // [RULE18] [RULE20] [RULE23]

   // horizontal position
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         h2 <= '0;
      else if (line_end_tick)
         h2 <= '0;
      else if (half_tick)
         h2 <= h2 + 12'h001;
   end

   // vertical position
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         v <= '0;
      else if (frame_start_tick)
         v <= '0;
      else if (line_end_tick)
         v <= v + 11'h001;
   end

   // shift phase; realigned at each window start, free otherwise
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         sph <= '0;
      else if (half_tick)
      begin
         if (h2 == win_start - 12'h001)
            sph <= '0;
         else if (sph == {shift_half, 1'b0} - 5'h01)
            sph <= '0;
         else
            sph <= sph + 5'h01;
      end
   end

   // pixel staging; one word waits ahead so a load never stalls
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         stage <= plt_pkg::BUS_RESET;
         stage_valid <= 1'b0;
         req <= 1'b0;
      end
      else
      begin
         if (req)
         begin
            stage <= PIXEL_DATA;
            stage_valid <= 1'b1;
         end
         else if (load)
            stage_valid <= 1'b0;
         req <= (load | ~stage_valid) & ~req;
      end
   end

   // power sequencing, decided only at frame boundaries
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         pstate <= plt_pkg::POWER_RESET;
         drain_left <= '0;
         power_on <= 1'b0;
      end
      else if (frame_start_tick)
      begin
         case (pstate)
            plt_pkg::PWR_OFF:
            begin
               // outputs come up on this frame, and power with them unless POWER_FORCE_OFF is set
               if (DISPLAY_ON & ~HW_POWER_SAVE)
               begin
                  pstate <= plt_pkg::PWR_RUN;          // [RULE2] [RULE5]
                  power_on <= ~POWER_FORCE_OFF;        // [RULE3] [RULE8]
               end
            end
            plt_pkg::PWR_RUN:
            begin
               if (~DISPLAY_ON)
               begin
                  pstate <= plt_pkg::PWR_OFF;
                  power_on <= 1'b0;
               end
               else if (HW_POWER_SAVE & POWER_FORCE_OFF)
               begin
                  pstate <= plt_pkg::PWR_OFF;          // [RULE4]
                  power_on <= 1'b0;
               end
               else if (HW_POWER_SAVE)
               begin
                  pstate <= plt_pkg::PWR_DRAIN;        // [RULE6]
                  drain_left <= DRAIN_FRAMES[plt_pkg::DRAIN_W-1:0];
                  power_on <= 1'b0;
               end
               else
                  power_on <= ~POWER_FORCE_OFF;        // [RULE9]
            end
            plt_pkg::PWR_DRAIN:
            begin
               // panel keeps its scan while its supply decays
               if (~HW_POWER_SAVE & DISPLAY_ON)
               begin
                  pstate <= plt_pkg::PWR_RUN;          // [RULE8]
                  power_on <= ~POWER_FORCE_OFF;
               end
               else if (~DISPLAY_ON | (drain_left <= 7'h01))
                  pstate <= plt_pkg::PWR_OFF;          // [RULE7]
               else
                  drain_left <= drain_left - 7'h01;    // [RULE7]
            end
            default:
            begin
               pstate <= plt_pkg::PWR_OFF;
               power_on <= 1'b0;
            end
         endcase
      end
   end

   assign run = (pstate != plt_pkg::PWR_OFF);

   // modulation flips once per line, one pixel period into the pulse
   assign ac_flip = step_first
      & (h2 == 12'(plt_pkg::HALVES_PER_TS * plt_pkg::AC_DELAY_TS));

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         ac_phase <= 1'b0;
      else
         ac_phase <= ac_phase ^ ac_flip; // [RULE16]
   end

   // panel values before gating
   always_comb
   begin
      next_line = (h2 < 12'(plt_pkg::HALVES_PER_TS
         * plt_pkg::LINE_PULSE_TS)); // [RULE15]
      // frame pulse spans the previous line's tail into the first line
      next_frame = (last_v & (h2 >= 12'(plt_pkg::HALVES_PER_TS
         * (plt_pkg::LINE_PULSE_TS + plt_pkg::FRAME_HOLD_TS))))
         | ((v == '0) & (h2 < 12'(plt_pkg::HALVES_PER_TS
         * (plt_pkg::LINE_PULSE_TS + plt_pkg::FRAME_HOLD_TS)))); // [RULE14]
      // low half first, then high; the gate hides it outside the window
      next_shift = (sph >= {1'b0, shift_half})
         & (in_window | ~CFG.shift_gate); // [RULE22]
      next_de = in_data;
      if (load)
         next_bus = (CFG.format == plt_pkg::FMT_MONO8) ? stage
            : (stage & 8'hF0);         // [RULE18] [RULE23]
      else if (in_data)
         next_bus = PANEL_PIXEL_BUS;
      else
         next_bus = plt_pkg::BUS_RESET;
   end

   // panel pins, all held low while the outputs are inactive
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         PANEL_LINE_PULSE <= 1'b0;
         PANEL_FRAME_PULSE <= 1'b0;
         PANEL_SHIFT_CLOCK <= 1'b0;
         PANEL_PIXEL_BUS <= plt_pkg::BUS_RESET;
         PANEL_DATA_ENABLE <= 1'b0;
         PANEL_AC_MODULATION <= 1'b0;
         PANEL_POWER_ENABLE <= 1'b0;
         out_on <= 1'b0;
      end
      else
      begin
         PANEL_LINE_PULSE <= run & next_line;
         PANEL_FRAME_PULSE <= run & next_frame;
         PANEL_SHIFT_CLOCK <= run & next_shift;
         PANEL_PIXEL_BUS <= run ? next_bus : plt_pkg::BUS_RESET;
         PANEL_DATA_ENABLE <= run & next_de;
         PANEL_AC_MODULATION <= run & (ac_phase ^ ac_flip);
         PANEL_POWER_ENABLE <= run & power_on;  // [RULE3]
         out_on <= run;
      end
   end

   assign PIXEL_REQ = req;

   // monitors for the checks below
   logic [plt_pkg::MON_W-1:0] ts_cyc;    // core cycles per pixel period
   logic [plt_pkg::MON_W-1:0] hi_cnt;
   logic [plt_pkg::MON_W-1:0] lo_cnt;
   logic [plt_pkg::MON_W-1:0] per_cnt;
   logic [plt_pkg::MON_W-1:0] drain_seen;
   logic line_seen;
   logic line_q;

   assign ts_cyc = CFG.clk_div ? 16'h0004 : 16'h0002;

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         hi_cnt <= '0;
         lo_cnt <= '0;
         per_cnt <= '0;
         drain_seen <= '0;
         line_seen <= 1'b0;
         line_q <= 1'b0;
      end
      else
      begin
         line_q <= PANEL_LINE_PULSE;
         hi_cnt <= PANEL_LINE_PULSE ? hi_cnt + 16'h0001 : '0;
         lo_cnt <= PANEL_LINE_PULSE ? '0 : lo_cnt + 16'h0001;
         per_cnt <= (PANEL_LINE_PULSE & ~line_q) ? 16'h0001
            : per_cnt + 16'h0001;
         line_seen <= out_on & (line_seen | (PANEL_LINE_PULSE & ~line_q));
         if (pstate != plt_pkg::PWR_DRAIN)
            drain_seen <= '0;
         else if (frame_start_tick)
            drain_seen <= drain_seen + 16'h0001;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   line_width_a: assert property ( // [RULE15]
      $fell(PANEL_LINE_PULSE) && out_on
         |-> hi_cnt == 16'(plt_pkg::LINE_PULSE_TS) * ts_cyc)
      else $error("line pulse width wrong");

   line_period_a: assert property ( // [RULE15]
      $rose(PANEL_LINE_PULSE) && line_seen
         |-> per_cnt == 16'(line_halves) * (ts_cyc >> 1))
      else $error("line period wrong");

   frame_hold_a: assert property ( // [RULE14]
      $fell(PANEL_FRAME_PULSE) && out_on
         |-> !PANEL_LINE_PULSE
         && lo_cnt == 16'(plt_pkg::FRAME_HOLD_TS) * ts_cyc)
      else $error("frame pulse hold wrong");

   ac_delay_a: assert property ( // [RULE16]
      $changed(PANEL_AC_MODULATION) && out_on && $past(out_on)
         |-> PANEL_LINE_PULSE && hi_cnt == ts_cyc)
      else $error("modulation change misplaced");

   shift_lead_a: assert property ( // [RULE17]
      $rose(PANEL_SHIFT_CLOCK) && CFG.shift_gate && !PANEL_LINE_PULSE
         |-> lo_cnt >= 16'(plt_pkg::SHIFT_LEAD_TS) * ts_cyc)
      else $error("shift rise too early");

   power_gate_a: assert property ( // [RULE3]
      PANEL_POWER_ENABLE |-> out_on)
      else $error("power without live outputs");

   force_off_a: assert property ( // [RULE9]
      frame_start_tick && POWER_FORCE_OFF |=> ##1 !PANEL_POWER_ENABLE)
      else $error("power kept under force-off");

   frame_align_a: assert property ( // [RULE2]
      $rose(out_on) |-> $past(frame_start_tick, 2))
      else $error("outputs started off a frame edge");

   drain_len_a: assert property ( // [RULE7]
      $past(pstate) == plt_pkg::PWR_DRAIN && pstate == plt_pkg::PWR_OFF
         && $past(HW_POWER_SAVE) && $past(DISPLAY_ON)
         |-> drain_seen == 16'(DRAIN_FRAMES))
      else $error("drain length wrong");

   idle_bus_a: assert property ( // [RULE18]
      !PANEL_DATA_ENABLE || CFG.format != plt_pkg::FMT_MONO8
         |-> PANEL_PIXEL_BUS[3:0] == 4'h0)
      else $error("low data lines driven");

   drain_done_c: cover property (
      $past(pstate) == plt_pkg::PWR_DRAIN && pstate == plt_pkg::PWR_OFF);
   resume_c: cover property (
      $past(pstate) == plt_pkg::PWR_DRAIN && pstate == plt_pkg::PWR_RUN);
   color_shift_c: cover property (
      CFG.format == plt_pkg::FMT_COLOR4 && $rose(PANEL_SHIFT_CLOCK));
   mono8_data_c: cover property (
      CFG.format == plt_pkg::FMT_MONO8 && $rose(PANEL_DATA_ENABLE));

endmodule : plt_panel_timing

// >>> dv/plt_panel_model.sv
// panel-side model that measures the timing seen on the panel pins
`timescale 1ns/1ps
module plt_panel_model (
   // clock
   input wire logic clk,
   // panel pins
   input wire logic line_pulse,
   input wire logic frame_pulse,
   input wire logic shift_clock,
   input wire logic [7:0] pixel_bus,
   input wire logic data_enable,
   input wire logic ac_modulation
);
   // figures in core cycles
   int cyc, nlines, lines, nrise, de_cnt;
   int t_lrise, t_lfall, t_frise, t_srise, t_sfall;
   int line_period, line_width, mod_delay, first_lead, tail_lead;
   int frame_hold, frame_setup, frame_lines;
   int act_rises, blank_rises, shift_high, de_len;
   bit first_seen, had_de;
   logic pl = 1'b0;
   logic pf = 1'b0;
   logic ps = 1'b0;
   logic pa = 1'b0;
   // words the panel latched on falls
   logic [7:0] got_q[$];

   // sample mid-cycle, where registered pins have settled
   always @(negedge clk)
   begin
      cyc++;
      if (line_pulse && !pl)
      begin
         line_period = cyc - t_lrise;
         t_lrise = cyc;
         // only a line that carried data has a last fall
         if (had_de)
         begin
            tail_lead = cyc - t_sfall;
            act_rises = nrise;
            de_len = de_cnt;
         end
         else
            blank_rises = nrise;
         nrise = 0;
         de_cnt = 0;
         had_de = 0;
         nlines++;
         lines++;
      end
      if (!line_pulse && pl)
      begin
         line_width = cyc - t_lrise;
         t_lfall = cyc;
         first_seen = 0;
         if (frame_pulse)
            frame_setup = cyc - t_frise;
      end
      if (ac_modulation !== pa)
         mod_delay = cyc - t_lrise;
      if (shift_clock && !ps)
      begin
         if (!first_seen && !line_pulse)
            first_lead = cyc - t_lfall;
         first_seen = 1;
         t_srise = cyc;
         nrise++;
      end
      // latch on the falling shift edge inside the window
      if (!shift_clock && ps && data_enable)
      begin
         shift_high = cyc - t_srise;
         t_sfall = cyc;
         got_q.push_back(pixel_bus);
      end
      if (data_enable)
      begin
         had_de = 1;
         de_cnt++;
      end
      if (frame_pulse && !pf)
      begin
         t_frise = cyc;
         frame_lines = lines;
         lines = 0;
      end
      if (!frame_pulse && pf)
         frame_hold = cyc - t_lfall;
      pl = line_pulse;
      pf = frame_pulse;
      ps = shift_clock;
      pa = ac_modulation;
   end
endmodule : plt_panel_model

// >>> dv/tb_top.sv
// self-checking bench for the passive panel timing generator
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   fails++; $display("Error at %0t: got %0h expected %0h", $time, got, \
   exp); end end
module tb_top;
   // geometry fields and a short drain
   localparam int HA = 1;
   localparam int HB = 1;
   localparam int VA = 1;
   localparam int VB = 2;
   localparam int DRAIN = 3;
   logic CORE_CLK = 1'b0;
   logic RESET = 1'b1;
   plt_pkg::plt_cfg_t CFG = '0;
   logic DISPLAY_ON = 1'b0;
   logic HW_POWER_SAVE = 1'b0;
   logic POWER_FORCE_OFF = 1'b0;
   logic [7:0] PIXEL_DATA = 8'h00;
   logic PIXEL_REQ, PANEL_LINE_PULSE, PANEL_FRAME_PULSE, PANEL_SHIFT_CLOCK;
   logic PANEL_DATA_ENABLE, PANEL_AC_MODULATION, PANEL_POWER_ENABLE;
   logic [7:0] PANEL_PIXEL_BUS;
   int fails = 0;
   int comparisons = 0;
   int tsc, line_len, frame_len, quiet; // core cycles
   logic [31:0] seed = 32'hA590;
   logic [7:0] exp_q[$]; // words handed to the design
   int hh_tab[3] = '{4, 8, 1}; // shift half cycle, half pixel periods

   always #2.5 CORE_CLK = ~CORE_CLK;

   plt_panel_timing #(.DRAIN_FRAMES(DRAIN)) plt_panel_timing_inst (
      .CORE_CLK(CORE_CLK), .RESET(RESET), .CFG(CFG),
      .DISPLAY_ON(DISPLAY_ON), .HW_POWER_SAVE(HW_POWER_SAVE),
      .POWER_FORCE_OFF(POWER_FORCE_OFF), .PIXEL_DATA(PIXEL_DATA),
      .PIXEL_REQ(PIXEL_REQ), .PANEL_LINE_PULSE(PANEL_LINE_PULSE),
      .PANEL_FRAME_PULSE(PANEL_FRAME_PULSE),
      .PANEL_SHIFT_CLOCK(PANEL_SHIFT_CLOCK),
      .PANEL_PIXEL_BUS(PANEL_PIXEL_BUS),
      .PANEL_DATA_ENABLE(PANEL_DATA_ENABLE),
      .PANEL_AC_MODULATION(PANEL_AC_MODULATION),
      .PANEL_POWER_ENABLE(PANEL_POWER_ENABLE));

   plt_panel_model panel (
      .clk(CORE_CLK), .line_pulse(PANEL_LINE_PULSE),
      .frame_pulse(PANEL_FRAME_PULSE), .shift_clock(PANEL_SHIFT_CLOCK),
      .pixel_bus(PANEL_PIXEL_BUS), .data_enable(PANEL_DATA_ENABLE),
      .ac_modulation(PANEL_AC_MODULATION));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // fresh random pixel word each cycle
   always @(posedge CORE_CLK)
   begin
      #1;
      seed = lfsr_next(seed);
      PIXEL_DATA = seed[7:0];
   end

   // a word is taken at the edge ending a request cycle
   always @(negedge CORE_CLK)
      if (PIXEL_REQ === 1'b1)
         exp_q.push_back(PIXEL_DATA);

   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK);
      #1;
   endtask : tick

   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task automatic set_cfg(input int f, input logic div, input logic gate);
      CFG.h_active = 7'(HA);
      CFG.h_blank = {seed[10:8], 5'(HB)}; // top bits must not matter
      CFG.v_active = 10'(VA);
      CFG.v_blank = 6'(VB);
      CFG.format = plt_pkg::plt_format_t'(f);
      CFG.clk_div = div;
      CFG.shift_gate = gate;
      tsc = div ? 4 : 2;
      line_len = ((HA + 1) * 8 + (HB + 4) * 8) * tsc;
      frame_len = (VA + 1 + VB) * line_len;
      quiet = line_len + 4;
   endtask : set_cfg

   task automatic wait_line(input int lim, output int el);
      int n0;
      n0 = panel.nlines;
      el = 0;
      while (panel.nlines == n0 && el <= lim)
      begin
         tick(1);
         el++;
      end
   endtask : wait_line

   task automatic wait_pwr(input logic v, output int el);
      el = 0;
      while (PANEL_POWER_ENABLE !== v && el <= frame_len + 2)
      begin
         tick(1);
         el++;
      end
   endtask : wait_pwr

   // cycles to the last line pulse before the pins fall quiet
   task automatic run_out(output int last);
      int el, tot;
      tot = 0;
      last = 0;
      el = 0;
      while (el <= quiet)
      begin
         wait_line(quiet, el);
         tot += el;
         if (el <= quiet)
            last = tot;
      end
   endtask : run_out

   task automatic start_run();
      int el;
      RESET = 1'b1;
      DISPLAY_ON = 1'b0;
      HW_POWER_SAVE = 1'b0;
      POWER_FORCE_OFF = 1'b0;
      tick(16);
      RESET = 1'b0;
      exp_q.delete();
      panel.got_q.delete();
      DISPLAY_ON = 1'b1;
      wait_line(frame_len + 4, el);
      `CHK(el <= frame_len + 2, 1'b1)
      // words used up while the pins were still off never reach the panel
      while (exp_q.size() > 1)
         exp_q.pop_front();
      `CHK(PANEL_POWER_ENABLE, 1'b1)
   endtask : start_run

   task automatic check_format(input int f);
      int hh, n;
      logic [7:0] w;
      hh = hh_tab[f];
      tick(3 * frame_len);
      `CHK(panel.line_period, line_len)
      `CHK(panel.line_width, 9 * tsc)
      `CHK(panel.mod_delay, tsc)
      `CHK(panel.first_lead, 23 * tsc)
      `CHK(panel.frame_hold, 9 * tsc)
      `CHK(panel.frame_setup, line_len - 9 * tsc)
      `CHK(panel.frame_lines, VA + 1 + VB)
      `CHK(panel.de_len, (HA + 1) * 8 * tsc)
      `CHK(panel.act_rises, (HA + 1) * 8 / hh)
      `CHK(panel.shift_high, hh * tsc / 2)
      `CHK(panel.tail_lead, (16 * HB + hh) * tsc / 2)
      `CHK(panel.blank_rises, 0)
      n = panel.got_q.size();
      `CHK(n > 0 && n <= exp_q.size(), 1'b1)
      for (int i = 0; i < n && i < exp_q.size(); i++)
      begin
         w = (hh == 8) ? exp_q[i] : {exp_q[i][7:4], 4'h0};
         `CHK(panel.got_q[i], w)
      end
   endtask : check_format

   task automatic power_test();
      int el, last;
      logic [12:0] pins;
      bit ok;
      set_cfg(0, 1'b0, 1'b1);
      start_run();
      POWER_FORCE_OFF = 1'b1;
      wait_pwr(1'b0, el);
      `CHK(el <= frame_len + 2, 1'b1)
      wait_line(quiet, el);
      `CHK(el <= line_len, 1'b1)
      POWER_FORCE_OFF = 1'b0;
      wait_pwr(1'b1, el);
      `CHK(el <= frame_len + 2, 1'b1)
      // forced off: save stops the pins with no drain
      POWER_FORCE_OFF = 1'b1;
      HW_POWER_SAVE = 1'b1;
      run_out(last);
      `CHK(last <= frame_len + 2, 1'b1)
      pins = {PANEL_LINE_PULSE, PANEL_FRAME_PULSE, PANEL_SHIFT_CLOCK,
         PANEL_DATA_ENABLE, PANEL_AC_MODULATION, PANEL_PIXEL_BUS};
      `CHK(pins, 13'h0)
      HW_POWER_SAVE = 1'b0;
      wait_line(frame_len + 4, el);
      `CHK(el <= frame_len + 2, 1'b1)
      `CHK(PANEL_POWER_ENABLE, 1'b0)
      POWER_FORCE_OFF = 1'b0;
      wait_pwr(1'b1, el);
      // unforced: power drops, then the pins drain
      HW_POWER_SAVE = 1'b1;
      wait_pwr(1'b0, el);
      `CHK(el <= frame_len + 2, 1'b1)
      run_out(last);
      ok = last >= (DRAIN - 1) * frame_len - line_len
         && last <= DRAIN * frame_len;
      `CHK(ok, 1'b1)
      HW_POWER_SAVE = 1'b0;
      wait_line(frame_len + 4, el);
      `CHK(el <= frame_len + 2, 1'b1)
      `CHK(PANEL_POWER_ENABLE, 1'b1)
      // release in mid-drain restores power
      HW_POWER_SAVE = 1'b1;
      wait_pwr(1'b0, el);
      tick(frame_len);
      HW_POWER_SAVE = 1'b0;
      wait_pwr(1'b1, el);
      `CHK(el <= frame_len + 2, 1'b1)
   endtask : power_test

   // watchdog, well above the expected run length
   initial
   begin
      #400000;
      fails++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial
   begin
      for (int f = 0; f < 3; f++)
      begin
         set_cfg(f, 1'b0, 1'b1);
         start_run();
         check_format(f);
         $display("test format %0d done", f);
      end
      set_cfg(0, 1'b1, 1'b1);
      start_run();
      check_format(0);
      $display("test halved clock done");
      // spare format code runs as mono4
      set_cfg(3, 1'b0, 1'b0);
      start_run();
      tick(3 * frame_len);
      `CHK(panel.blank_rises > 0, 1'b1)
      $display("test free shift done");
      power_test();
      $display("test power done");
      report_and_stop();
   end
endmodule : tb_top
